// ### hw/fill_if.sv
// Link between command controller and filter fill tracker
interface fill_if;
  logic [5:0] tapCount;
  logic sample;
  logic flush;
  logic filled;
  logic [5:0] fillCount;
  modport ctrl(output tapCount, sample, flush, input filled, fillCount);
  modport tracker(input tapCount, sample, flush, output filled, fillCount);
endinterface

// ### hw/fill_tracker.sv
// Counts samples entering the smoothing filter until every tap holds one
module fill_tracker
  import sensor_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  fill_if.tracker fl
);
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic full_ff;
  logic nxt_full;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (fl.flush) begin
      nxt_cnt = 6'h00;
    end else if (fl.sample && (cnt_ff < fl.tapCount)) begin
      nxt_cnt = cnt_ff + 6'h01;
    end
    nxt_full = (nxt_cnt >= fl.tapCount);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_ff <= 6'h00;
      full_ff <= 1'b1;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      full_ff <= nxt_full;
    end
  end

  assign fl.filled = full_ff;
  assign fl.fillCount = cnt_ff;
endmodule // fill_tracker

// ### hw/sensor_cmd_ctrl.sv
// Setting, smoothing filter and single-shot mode command controller
//
// The APB register port and the register addresses were chosen for this implementation.
module sensor_cmd_ctrl
  import sensor_cmd_pkg::*;
#(
  parameter logic [7:0] SET_WRITE_ID = 8'h06,
  parameter int MAX_TAPS = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxFirst,
  input wire logic rxLast,
  input wire logic lineActivity,
  input wire logic txReady,
  output logic txValid,
  output logic [7:0] txData,
  output logic txFirst,
  output logic txLast,
  input wire logic sampleValid,
  input wire logic reportDone,
  output logic readingOk,
  output logic measureReq,
  output logic syncMode,
  output logic angleUnitMils,
  output logic [12:0] unitsPerTurn,
  output logic attitudeDuringCal,
  output logic [2:0] magSlot,
  output logic [1:0] accelSlot,
  output logic byteOrderBig,
  output logic [3:0] lineRateIdx
);
  fill_if fl ();

  // Coefficient stores: staged during a load, committed when it checks out
  logic [63:0] taps_ff [MAX_TAPS];
  logic [63:0] shadow_ff [MAX_TAPS];

  logic [7:0] frameId_ff, nxt_frameId;
  logic [8:0] byteIdx_ff, nxt_byteIdx;
  logic [7:0] argId_ff, nxt_argId;
  logic [7:0] ldCount_ff, nxt_ldCount;
  logic hdrOk_ff, nxt_hdrOk;
  logic [31:0] value_ff, nxt_value;
  logic mils_ff, nxt_mils;
  logic attCal_ff, nxt_attCal;
  logic [2:0] mag_ff, nxt_mag;
  logic [1:0] accel_ff, nxt_accel;
  logic order_ff, nxt_order;
  logic [3:0] rate_ff, nxt_rate;
  logic [5:0] tapCnt_ff, nxt_tapCnt;
  logic [12:0] turn_ff, nxt_turn;
  logic tapWe, commitTaps, loadReject, selCont, selSync;
  logic [4:0] tapWsel;
  logic [2:0] tapWlane;
  logic [8:0] nBytes, k;
  reply_t startKind;
  logic [7:0] curId;
  logic [1:0] leLane;
  logic commitDly_ff;

  function automatic logic countOk(input logic [7:0] c);
    countOk = ((c == 8'h00) || (c == 8'h04) || (c == 8'h08) ||
               (c == 8'h10) || (c == 8'h20)) && (32'(c) <= MAX_TAPS);
  endfunction

  // Value width in bytes of a setting, zero when unknown
  function automatic logic [2:0] valWidth(input logic [7:0] id);
    case (id)
      SID_BYTE_ORDER, SID_LINE_RATE, SID_ANGLE_UNIT, SID_ATT_CAL:
        valWidth = 3'h1;
      SID_MAG_SLOT, SID_ACCEL_SLOT: valWidth = 3'h4;
      default: valWidth = 3'h0;
    endcase
  endfunction

  function automatic logic [31:0] settingVal(input logic [7:0] id);
    case (id)
      SID_BYTE_ORDER: settingVal = {31'h0, order_ff};
      SID_LINE_RATE: settingVal = {28'h0, rate_ff};
      SID_ANGLE_UNIT: settingVal = {31'h0, mils_ff};
      SID_ATT_CAL: settingVal = {31'h0, attCal_ff};
      SID_MAG_SLOT: settingVal = {29'h0, mag_ff};
      SID_ACCEL_SLOT: settingVal = {30'h0, accel_ff};
      default: settingVal = 32'h0000_0000;
    endcase
  endfunction

  always_comb begin
    nxt_frameId = frameId_ff;
    nxt_byteIdx = byteIdx_ff;
    nxt_argId = argId_ff;
    nxt_ldCount = ldCount_ff;
    nxt_hdrOk = hdrOk_ff;
    nxt_value = value_ff;
    nxt_mils = mils_ff;
    nxt_attCal = attCal_ff;
    nxt_mag = mag_ff;
    nxt_accel = accel_ff;
    nxt_order = order_ff;
    nxt_rate = rate_ff;
    nxt_tapCnt = tapCnt_ff;
    tapWe = 1'b0;
    commitTaps = 1'b0;
    loadReject = 1'b0;
    selCont = 1'b0;
    selSync = 1'b0;
    startKind = RPL_NONE;
    k = byteIdx_ff - 9'h003;
    leLane = byteIdx_ff[1:0] - 2'h1;
    tapWsel = k[7:3];
    tapWlane = k[2:0];
    curId = rxFirst ? rxData : frameId_ff;
    nBytes = rxFirst ? 9'h000 : byteIdx_ff + 9'h001;
    if (rxValid) begin
      if (rxFirst) begin
        nxt_frameId = rxData;
        nxt_byteIdx = 9'h000;
        nxt_value = 32'h0000_0000;
        nxt_hdrOk = 1'b1;
      end else begin
        nxt_byteIdx = byteIdx_ff + 9'h001;
        if (byteIdx_ff == 9'h000) begin
          nxt_argId = rxData;
          nxt_hdrOk = (rxData == TAPS_FIXED0);
        end
        if ((byteIdx_ff == 9'h001) && (rxData != TAPS_FIXED1)) begin
          nxt_hdrOk = 1'b0;
        end
        if (byteIdx_ff == 9'h002) begin
          nxt_ldCount = rxData;
        end
        if ((byteIdx_ff >= 9'h001) && (byteIdx_ff <= 9'h004)) begin
          if (order_ff) begin
            nxt_value = {value_ff[23:0], rxData};
          end else begin
            nxt_value[8*leLane +: 8] = rxData;
          end
        end
        if ((frameId_ff == FRM_TAPS_LOAD) && (byteIdx_ff >= 9'h003) &&
            (byteIdx_ff < 9'h103)) begin
          tapWe = (32'(tapWsel) < MAX_TAPS);
        end
      end
      if (rxLast) begin
        if (curId == SET_WRITE_ID) begin
          startKind = RPL_WACK;
          case (nxt_argId)
            SID_BYTE_ORDER: nxt_order = (nxt_value != 32'h0);
            SID_LINE_RATE:
              if (nxt_value <= 32'(LINE_RATE_MAX)) begin
                nxt_rate = nxt_value[3:0];
              end
            SID_ANGLE_UNIT: nxt_mils = (nxt_value != 32'h0);
            SID_ATT_CAL: nxt_attCal = (nxt_value != 32'h0);
            SID_MAG_SLOT:
              if (nxt_value <= 32'h0000_0007) begin
                nxt_mag = nxt_value[2:0];
              end
            SID_ACCEL_SLOT:
              if (nxt_value <= 32'(ACCEL_SLOT_MAX)) begin
                nxt_accel = nxt_value[1:0];
              end
            default: ;
          endcase
        end else if (curId == FRM_SET_READ) begin
          startKind = RPL_READ;
        end else if (curId == FRM_TAPS_LOAD) begin
          startKind = RPL_TACK;
          if (nxt_hdrOk && countOk(nxt_ldCount) &&
              (nBytes == {nxt_ldCount[5:0], 3'b000} + 9'h003)) begin
            commitTaps = 1'b1;
            nxt_tapCnt = nxt_ldCount[5:0];
          end else begin
            loadReject = 1'b1;
          end
        end else if ((curId == FRM_TAPS_READ) && nxt_hdrOk) begin
          startKind = RPL_TREAD;
        end else if (curId == FRM_MODE_SEL) begin
          startKind = RPL_MODE;
          selCont = (nxt_argId == MODE_ID_CONT);
          selSync = (nxt_argId == MODE_ID_SYNC);
        end
      end
    end
    nxt_turn = nxt_mils ? MILS_PER_TURN : DEG_PER_TURN;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frameId_ff <= 8'h00;
      byteIdx_ff <= 9'h000;
      argId_ff <= 8'h00;
      ldCount_ff <= 8'h00;
      hdrOk_ff <= 1'b0;
      value_ff <= 32'h0000_0000;
      mils_ff <= RST_ANGLE_UNIT;
      attCal_ff <= RST_ATT_CAL;
      mag_ff <= RST_MAG_SLOT;
      accel_ff <= RST_ACCEL_SLOT;
      order_ff <= RST_BYTE_ORDER;
      rate_ff <= RST_LINE_RATE;
      tapCnt_ff <= RST_TAP_COUNT;
      turn_ff <= DEG_PER_TURN;
      commitDly_ff <= 1'b0;
    end else if (ce) begin
      frameId_ff <= nxt_frameId;
      byteIdx_ff <= nxt_byteIdx;
      argId_ff <= nxt_argId;
      ldCount_ff <= nxt_ldCount;
      hdrOk_ff <= nxt_hdrOk;
      value_ff <= nxt_value;
      mils_ff <= nxt_mils;
      attCal_ff <= nxt_attCal;
      mag_ff <= nxt_mag;
      accel_ff <= nxt_accel;
      order_ff <= nxt_order;
      rate_ff <= nxt_rate;
      tapCnt_ff <= nxt_tapCnt;
      turn_ff <= nxt_turn;
      commitDly_ff <= commitTaps;
    end
  end

  // Coefficient storage, canonical value regardless of byte order
  always_ff @(posedge sys_clk) begin
    if (ce && tapWe) begin
      if (order_ff) begin
        shadow_ff[tapWsel][8*(3'h7-tapWlane) +: 8] <= rxData;
      end else begin
        shadow_ff[tapWsel][8*tapWlane +: 8] <= rxData;
      end
    end
    // Copy a cycle late so the final coefficient byte is included
    if (ce && commitDly_ff) begin
      for (int i = 0; i < MAX_TAPS; i++) begin
        taps_ff[i] <= shadow_ff[i];
      end
    end
  end

  // Reply sequencer
  tx_state_t tx_ff, nxt_tx;
  reply_t kind_ff, nxt_kind;
  logic [8:0] txIdx_ff, nxt_txIdx;
  logic txValid_ff, nxt_txValid, txFirst_ff, nxt_txFirst;
  logic txLast_ff, nxt_txLast;
  logic [7:0] txData_ff, nxt_txData;
  logic modeReplyDone;

  function automatic logic [8:0] replyLast(input reply_t kd);
    case (kd)
      RPL_READ: replyLast = 9'h001 + {6'h00, valWidth(argId_ff)};
      RPL_TREAD: replyLast = {tapCnt_ff, 3'b000} + 9'h003;
      RPL_MODE: replyLast = 9'h001;
      default: replyLast = 9'h000;
    endcase
  endfunction

  function automatic logic [7:0] replyByte(input reply_t kd,
                                           input logic [8:0] i);
    logic [2:0] w;
    logic [31:0] v;
    logic [8:0] q;
    w = valWidth(argId_ff);
    v = settingVal(argId_ff);
    q = i - 9'h004;
    replyByte = 8'h00;
    case (kd)
      RPL_WACK: replyByte = FRM_SET_WRITE_ACK;
      RPL_TACK: replyByte = FRM_TAPS_ACK;
      RPL_MODE: replyByte = (i == 9'h000) ? FRM_MODE_REPLY : argId_ff;
      RPL_READ:
        if (i == 9'h000) begin
          replyByte = FRM_SET_READ_REPLY;
        end else if (i == 9'h001) begin
          replyByte = argId_ff;
        end else if (order_ff) begin
          replyByte = v[8*(w-i[2:0]+3'h1) +: 8];
        end else begin
          replyByte = v[8*(i[2:0]-3'h2) +: 8];
        end
      RPL_TREAD:
        if (i == 9'h000) begin
          replyByte = FRM_TAPS_REPLY;
        end else if (i == 9'h001) begin
          replyByte = TAPS_FIXED0;
        end else if (i == 9'h002) begin
          replyByte = TAPS_FIXED1;
        end else if (i == 9'h003) begin
          replyByte = {2'b00, tapCnt_ff};
        end else if (order_ff) begin
          replyByte = taps_ff[q[7:3]][8*(3'h7-q[2:0]) +: 8];
        end else begin
          replyByte = taps_ff[q[7:3]][8*q[2:0] +: 8];
        end
      default: replyByte = 8'h00;
    endcase
  endfunction

  assign modeReplyDone = (tx_ff == TX_SEND) && txReady && txLast_ff &&
                         (kind_ff == RPL_MODE);

  always_comb begin
    nxt_tx = tx_ff;
    nxt_kind = kind_ff;
    nxt_txIdx = txIdx_ff;
    nxt_txValid = txValid_ff;
    nxt_txFirst = txFirst_ff;
    nxt_txLast = txLast_ff;
    nxt_txData = txData_ff;
    unique case (tx_ff)
      TX_IDLE:
        if (startKind != RPL_NONE) begin
          nxt_tx = TX_SEND;
          nxt_kind = startKind;
          nxt_txIdx = 9'h000;
          nxt_txValid = 1'b1;
          nxt_txFirst = 1'b1;
          nxt_txLast = (startKind == RPL_WACK) || (startKind == RPL_TACK);
          nxt_txData = replyByte(startKind, 9'h000);
        end
      TX_SEND:
        if (txReady) begin
          if (txLast_ff) begin
            nxt_tx = TX_IDLE;
            nxt_txValid = 1'b0;
            nxt_txFirst = 1'b0;
            nxt_txLast = 1'b0;
          end else begin
            nxt_txIdx = txIdx_ff + 9'h001;
            nxt_txFirst = 1'b0;
            nxt_txLast = (nxt_txIdx == replyLast(kind_ff));
            nxt_txData = replyByte(kind_ff, nxt_txIdx);
          end
        end
      default: nxt_tx = TX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_ff <= TX_IDLE;
      kind_ff <= RPL_NONE;
      txIdx_ff <= 9'h000;
      txValid_ff <= 1'b0;
      txFirst_ff <= 1'b0;
      txLast_ff <= 1'b0;
      txData_ff <= 8'h00;
    end else if (ce) begin
      tx_ff <= nxt_tx;
      kind_ff <= nxt_kind;
      txIdx_ff <= nxt_txIdx;
      txValid_ff <= nxt_txValid;
      txFirst_ff <= nxt_txFirst;
      txLast_ff <= nxt_txLast;
      txData_ff <= nxt_txData;
    end
  end

  // Operating mode
  mode_state_t mode_ff, nxt_mode;
  logic arm_ff, nxt_arm, meas_ff, nxt_meas;

  always_comb begin
    nxt_mode = mode_ff;
    nxt_arm = arm_ff;
    nxt_meas = 1'b0;
    unique case (mode_ff)
      MODE_RUN: ;
      MODE_DORMANT:
        if (lineActivity) begin
          nxt_mode = MODE_AWAKE;
          nxt_meas = 1'b1;
        end
      MODE_AWAKE:
        if (reportDone) begin
          nxt_mode = MODE_DORMANT;
        end
      default: nxt_mode = MODE_RUN;
    endcase
    if (selCont) begin
      nxt_mode = MODE_RUN;
      nxt_arm = 1'b0;
    end else if (selSync) begin
      nxt_arm = 1'b1;
    end else if (arm_ff && modeReplyDone) begin
      nxt_mode = MODE_AWAKE;
      nxt_arm = 1'b0;
      nxt_meas = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_ff <= MODE_RUN;
      arm_ff <= 1'b0;
      meas_ff <= 1'b0;
    end else if (ce) begin
      mode_ff <= nxt_mode;
      arm_ff <= nxt_arm;
      meas_ff <= nxt_meas;
    end
  end

  // APB slave, zero wait states
  logic flushEn_ff, nxt_flushEn, loadErr_ff, nxt_loadErr;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic [31:0] prdata_ff, nxt_prdata;
  logic apbWr;

  assign apbWr = psel && penable && pwrite && pready_ff && !pslverr_ff;

  always_comb begin
    nxt_flushEn = flushEn_ff;
    nxt_loadErr = loadErr_ff;
    nxt_pready = psel && !penable;
    nxt_pslverr = 1'b0;
    nxt_prdata = 32'h0000_0000;
    if (psel && !penable) begin
      case (paddr)
        ADDR_CONTROL: nxt_prdata = {31'h0, flushEn_ff};
        ADDR_STATUS:
          nxt_prdata = {10'h000, tapCnt_ff, 2'b00, fl.fillCount,
                        3'b000, loadErr_ff, fl.filled, mode_ff};
        ADDR_SETTINGS:
          nxt_prdata = {20'h0_0000, rate_ff, order_ff, accel_ff, mag_ff,
                        attCal_ff, mils_ff};
        default: nxt_pslverr = 1'b1;
      endcase
    end
    if (apbWr && (paddr == ADDR_CONTROL)) begin
      nxt_flushEn = pwdata[CTL_FLUSH_BIT];
      if (pwdata[CTL_CLR_ERR_BIT]) begin
        nxt_loadErr = 1'b0;
      end
    end
    if (loadReject) begin
      nxt_loadErr = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flushEn_ff <= RST_FLUSH_EN;
      loadErr_ff <= 1'b0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else if (ce) begin
      flushEn_ff <= nxt_flushEn;
      loadErr_ff <= nxt_loadErr;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff <= nxt_prdata;
    end
  end

  assign fl.tapCount = tapCnt_ff;
  assign fl.sample = sampleValid;
  assign fl.flush = (reportDone && flushEn_ff) || commitTaps;

  fill_tracker u_fill (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .fl(fl)
  );

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign txValid = txValid_ff;
  assign txData = txData_ff;
  assign txFirst = txFirst_ff;
  assign txLast = txLast_ff;
  assign readingOk = fl.filled;
  assign measureReq = meas_ff;
  assign syncMode = (mode_ff != MODE_RUN);
  assign angleUnitMils = mils_ff;
  assign unitsPerTurn = turn_ff;
  assign attitudeDuringCal = attCal_ff;
  assign magSlot = mag_ff;
  assign accelSlot = accel_ff;
  assign byteOrderBig = order_ff;
  assign lineRateIdx = rate_ff;
endmodule // sensor_cmd_ctrl

// ### hw/sensor_cmd_pkg.sv
// Shared constants and types for the sensor setting and filter command block
package sensor_cmd_pkg;
  // Frame identifiers
  localparam logic [7:0] FRM_SET_READ = 8'h07;
  localparam logic [7:0] FRM_SET_READ_REPLY = 8'h08;
  localparam logic [7:0] FRM_SET_WRITE_ACK = 8'h13;
  localparam logic [7:0] FRM_TAPS_LOAD = 8'h0C;
  localparam logic [7:0] FRM_TAPS_READ = 8'h0D;
  localparam logic [7:0] FRM_TAPS_REPLY = 8'h0E;
  localparam logic [7:0] FRM_TAPS_ACK = 8'h14;
  localparam logic [7:0] FRM_MODE_SEL = 8'h2E;
  localparam logic [7:0] FRM_MODE_REPLY = 8'h2F;
  // Setting identifiers
  localparam logic [7:0] SID_BYTE_ORDER = 8'h06;
  localparam logic [7:0] SID_LINE_RATE = 8'h0E;
  localparam logic [7:0] SID_ANGLE_UNIT = 8'h0F;
  localparam logic [7:0] SID_ATT_CAL = 8'h10;
  localparam logic [7:0] SID_MAG_SLOT = 8'h12;
  localparam logic [7:0] SID_ACCEL_SLOT = 8'h13;
  // Values after reset and ranges
  localparam logic RST_BYTE_ORDER = 1'b1;
  localparam logic [3:0] RST_LINE_RATE = 4'hC;
  localparam logic [3:0] LINE_RATE_MAX = 4'hE;
  localparam logic RST_ANGLE_UNIT = 1'b0;
  localparam logic RST_ATT_CAL = 1'b1;
  localparam logic [2:0] RST_MAG_SLOT = 3'h0;
  localparam logic [1:0] RST_ACCEL_SLOT = 2'h0;
  localparam logic [1:0] ACCEL_SLOT_MAX = 2'h2;
  localparam logic [5:0] RST_TAP_COUNT = 6'h00;
  localparam logic RST_FLUSH_EN = 1'b0;
  // Filter payload fixed bytes, mode identifiers
  localparam logic [7:0] TAPS_FIXED0 = 8'h03;
  localparam logic [7:0] TAPS_FIXED1 = 8'h01;
  localparam logic [7:0] MODE_ID_CONT = 8'h00;
  localparam logic [7:0] MODE_ID_SYNC = 8'h64;
  // Units per full turn
  localparam logic [12:0] MILS_PER_TURN = 13'h1900;
  localparam logic [12:0] DEG_PER_TURN = 13'h0168;
  // Register byte addresses
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_SETTINGS = 12'h008;
  localparam int CTL_FLUSH_BIT = 0;
  localparam int CTL_CLR_ERR_BIT = 1;

  typedef enum logic [2:0] {
    MODE_RUN = 3'b001,
    MODE_DORMANT = 3'b010,
    MODE_AWAKE = 3'b100
  } mode_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;

  typedef enum logic [2:0] {
    RPL_NONE = 3'h0,
    RPL_WACK = 3'h1,
    RPL_READ = 3'h2,
    RPL_TACK = 3'h3,
    RPL_TREAD = 3'h4,
    RPL_MODE = 3'h5
  } reply_t;
endpackage

// ### tb/sensor_cmd_chk.sv
// Port checker for the command controller
module sensor_cmd_chk
  import sensor_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [7:0] txData,
  input wire logic txFirst,
  input wire logic txLast,
  input wire logic measureReq,
  input wire logic syncMode,
  input wire logic angleUnitMils,
  input wire logic [12:0] unitsPerTurn
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_idAcc;
    txValid && txReady && txFirst && txData == FRM_MODE_REPLY;
  endsequence
  sequence s_syncAcc;
    txValid && txReady && txLast && txData == MODE_ID_SYNC;
  endsequence
  a_pready_timing: assert property (ce && psel && !penable |=> pready)
    else $error("no pready after setup");
  a_pready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_units_turn: assert property (unitsPerTurn ==
    (angleUnitMils ? MILS_PER_TURN : DEG_PER_TURN))
    else $error("units per turn wrong");
  a_tx_hold: assert property (txValid && !txReady |=> txValid &&
    $stable(txData) && $stable(txLast))
    else $error("reply byte not held");
  a_tx_first: assert property ($rose(txValid) |-> txFirst)
    else $error("reply does not start with id");
  a_tx_end: assert property (txValid && txReady && txLast |=> !txValid)
    else $error("reply runs past last byte");
  a_sync_meas: assert property (s_idAcc ##1 s_syncAcc |=> measureReq)
    else $error("no measurement after mode reply");
  a_meas_pulse: assert property (measureReq |=> !measureReq)
    else $error("measure request too long");
  a_meas_sync: assert property (measureReq |-> syncMode)
    else $error("measure request outside single shot");
endmodule // sensor_cmd_chk

bind sensor_cmd_ctrl sensor_cmd_chk u_chk(.sys_clk, .rst, .ce, .psel,
  .penable, .pready, .txValid, .txReady, .txData, .txFirst, .txLast,
  .measureReq, .syncMode, .angleUnitMils, .unitsPerTurn);

// ### tb/sensor_setting_filter_sync_cmds_tb_top.sv
// Testbench for the setting, filter and mode command controller
module sensor_setting_filter_sync_cmds_tb_top;
  import sensor_cmd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, r;
  logic pready, pslverr, er, rxValid, rxFirst, rxLast, lineActivity;
  logic [7:0] rxData, txData;
  logic txReady, txValid, txFirst, txLast, sampleValid = 0, reportDone = 0;
  logic readingOk, measureReq, syncMode, angleUnitMils, attitudeDuringCal;
  logic byteOrderBig;
  logic [12:0] unitsPerTurn;
  logic [2:0] magSlot;
  logic [1:0] accelSlot;
  logic [3:0] lineRateIdx;
  int errors = 0, n_tests = 0, nMeas = 0, m;
  localparam logic [7:0] SET_WRITE_ID = 8'h06;
  logic [7:0] q[$];
  typedef struct {logic [7:0] sid; int n; logic [31:0] v, rb, set;} row_t;
  row_t rows[8] = '{'{SID_ANGLE_UNIT, 1, 32'h1, 32'h1, 32'h0000_0C83},
    '{SID_ATT_CAL, 1, 32'h0, 32'h0, 32'h0000_0C81},
    '{SID_MAG_SLOT, 4, 32'h7, 32'h7, 32'h0000_0C9D},
    '{SID_MAG_SLOT, 4, 32'h8, 32'h7, 32'h0000_0C9D},
    '{SID_ACCEL_SLOT, 4, 32'h2, 32'h2, 32'h0000_0CDD},
    '{SID_ACCEL_SLOT, 4, 32'h3, 32'h2, 32'h0000_0CDD},
    '{SID_LINE_RATE, 1, 32'hE, 32'hE, 32'h0000_0EDD},
    '{SID_BYTE_ORDER, 1, 32'h0, 32'h0, 32'h0000_0E5D}};
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (measureReq === 1'b1) nMeas++;
  sensor_cmd_ctrl u_sensor_cmd_ctrl(.sys_clk, .rst, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rxValid, .rxData,
    .rxFirst, .rxLast, .lineActivity, .txReady, .txValid, .txData, .txFirst,
    .txLast, .sampleValid, .reportDone, .readingOk, .measureReq, .syncMode,
    .angleUnitMils, .unitsPerTurn, .attitudeDuringCal, .magSlot, .accelSlot,
    .byteOrderBig, .lineRateIdx);
  serial_host_model u_serial_host_model(.sys_clk, .txValid, .txData,
    .rxValid, .rxData, .rxFirst, .rxLast, .lineActivity, .txReady);
  task automatic chk(input string n, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reply(input logic [7:0] e[$]);
    int k;
    k = 0;
    while (u_serial_host_model.got.size() < e.size() && k < 500) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (3) @(posedge sys_clk);
    foreach (e[i]) chk("reply byte", e[i], u_serial_host_model.got[i]);
    chk("reply length", e.size(), u_serial_host_model.got.size());
    u_serial_host_model.got.delete();
  endtask
  task automatic samples(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      sampleValid <= 1'b1;
      @(posedge sys_clk);
      sampleValid <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic done();
    @(posedge sys_clk);
    reportDone <= 1'b1;
    @(posedge sys_clk);
    reportDone <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    apb(0, ADDR_SETTINGS, '0);
    chk("settings at reset", 32'h0000_0C82, r);
    chk("units at reset", DEG_PER_TURN, unitsPerTurn);
    apb(0, ADDR_STATUS, '0);
    chk("status at reset", 32'h0000_0009, r);
    apb(0, 12'h00C, '0);
    chk("unmapped error", 1, er);
    foreach (rows[i]) begin
      q = '{SET_WRITE_ID, rows[i].sid};
      for (int k = rows[i].n - 1; k >= 0; k--) q.push_back(rows[i].v[8*k+:8]);
      u_serial_host_model.send(q);
      reply('{FRM_SET_WRITE_ACK});
      apb(0, ADDR_SETTINGS, '0);
      chk("settings", rows[i].set, r);
      chk("pins", rows[i].set, {20'h0_0000, lineRateIdx,
        byteOrderBig, accelSlot, magSlot, attitudeDuringCal, angleUnitMils});
      u_serial_host_model.send('{FRM_SET_READ, rows[i].sid});
      q = '{FRM_SET_READ_REPLY, rows[i].sid};
      for (int k = rows[i].n - 1; k >= 0; k--) q.push_back(rows[i].rb[8*k+:8]);
      reply(q);
    end
    chk("mils per turn", MILS_PER_TURN, unitsPerTurn);
    u_serial_host_model.send('{SET_WRITE_ID, SID_MAG_SLOT, 8'h00, 8'h00,
      8'h00, 8'h01});
    reply('{FRM_SET_WRITE_ACK});
    u_serial_host_model.send('{FRM_SET_READ, SID_MAG_SLOT});
    reply('{FRM_SET_READ_REPLY, SID_MAG_SLOT, 8'h07, 8'h00, 8'h00,
      8'h00});
    q = '{FRM_TAPS_LOAD, TAPS_FIXED0, TAPS_FIXED1, 8'h04};
    for (int k = 0; k < 32; k++) q.push_back(8'(k + 1));
    u_serial_host_model.send(q);
    reply('{FRM_TAPS_ACK});
    samples(3);
    chk("not yet full", 0, readingOk);
    samples(1);
    chk("full", 1, readingOk);
    q[0] = FRM_TAPS_REPLY;
    u_serial_host_model.slow = 1'b1;
    u_serial_host_model.send('{FRM_TAPS_READ, TAPS_FIXED0, TAPS_FIXED1});
    reply(q);
    u_serial_host_model.slow = 1'b0;
    q[0] = FRM_TAPS_LOAD;
    q[3] = 8'h05;
    u_serial_host_model.send(q);
    reply('{FRM_TAPS_ACK});
    apb(0, ADDR_STATUS, '0);
    chk("tap count kept", 4, r[21:16]);
    chk("load error", 1, r[4]);
    apb(1, ADDR_CONTROL, 32'h0000_0003);
    apb(0, ADDR_STATUS, '0);
    chk("error cleared", 0, r[4]);
    done();
    chk("flushed", 0, readingOk);
    samples(4);
    chk("refilled", 1, readingOk);
    m = nMeas;
    u_serial_host_model.send('{FRM_MODE_SEL, MODE_ID_SYNC});
    reply('{FRM_MODE_REPLY, MODE_ID_SYNC});
    chk("measure on entry", m + 1, nMeas);
    done();
    apb(0, ADDR_STATUS, '0);
    chk("dormant", 3'b010, r[2:0]);
    u_serial_host_model.poke();
    repeat (3) @(posedge sys_clk);
    chk("one report", m + 2, nMeas);
    done();
    u_serial_host_model.poke();
    done();
    u_serial_host_model.send('{FRM_MODE_SEL, MODE_ID_CONT});
    reply('{FRM_MODE_REPLY, MODE_ID_CONT});
    apb(0, ADDR_STATUS, '0);
    chk("running", 3'b001, r[2:0]);
    chk("sync off", 0, syncMode);
    tally_and_finish();
  end
endmodule // sensor_setting_filter_sync_cmds_tb_top

// ### tb/serial_host_model.sv
// Host side of the serial link: sends frames, collects replies
module serial_host_model (
  input wire logic sys_clk,
  input wire logic txValid,
  input wire logic [7:0] txData,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxFirst,
  output logic rxLast,
  output logic lineActivity,
  output logic txReady
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  bit slow = 1'b0;
  initial begin
    {rxValid, rxFirst, rxLast, lineActivity, txReady} = '0;
    rxData = '0;
  end
  // Stalls every other cycle when slow
  always @(posedge sys_clk) begin
    if (txValid && txReady) got.push_back(txData);
    txReady <= slow ? !txReady : 1'b1;
  end
  task automatic send(input logic [7:0] b[$]);
    foreach (b[i]) begin
      @(posedge sys_clk);
      rxValid <= 1'b1;
      rxData <= b[i];
      rxFirst <= i == 0;
      rxLast <= i == b.size() - 1;
    end
    @(posedge sys_clk);
    rxValid <= 1'b0;
    rxFirst <= 1'b0;
    rxLast <= 1'b0;
    rxData <= ~rxData;
  endtask
  // One byte seen on the line
  task automatic poke();
    @(posedge sys_clk);
    lineActivity <= 1'b1;
    @(posedge sys_clk);
    lineActivity <= 1'b0;
  endtask
endmodule // serial_host_model
